// ---- dv/tb_xbcsal_top.sv ----
`timescale 1ns/1ps
`include "xbcsal_cfg.svh"
`define XB_CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
// self-checking bench for the access-lock block
module tb_xbcsal_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sb_wr = 1'b0;
  logic [2:0] sb_addr = 3'h0;
  logic [7:0] sb_wdata = 8'h00;
  logic [7:0] sb_rdata;
  logic       lpc_req, lpc_go, lpc_deny, acb_req, acb_go;
  logic [1:0] lpc_cs, acb_cs, mode, go_cs;
  logic [3:0] cs_lock;
  logic       wk_lock;
  int         n_errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  always #2.5 clk = ~clk;
  xbcsal_far_model far_i (.clk(clk), .lpc_req(lpc_req), .lpc_cs(lpc_cs),
    .acb_req(acb_req), .acb_cs(acb_cs));
  xbcsal_top xbcsal_top_i (.clk(clk), .rst(rst), .sb_addr(sb_addr), .sb_wr(sb_wr),
    .sb_wdata(sb_wdata), .sb_rdata(sb_rdata), .lpc_req(lpc_req), .lpc_cs(lpc_cs),
    .lpc_go(lpc_go), .lpc_deny(lpc_deny), .lpc_deny_mode(mode), .acb_req(acb_req),
    .acb_cs(acb_cs), .acb_go(acb_go), .go_cs(go_cs), .wakeup_ctrl_host_lock(wk_lock),
    .cs_host_lock(cs_lock));
  // register port: one-cycle write strobe, read data one cycle after the address
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    sb_addr = a;
    sb_wdata = d;
    sb_wr = 1'b1;
    @(negedge clk);
    sb_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk);
    sb_addr = a;
    @(negedge clk);
    `XB_CHK("sb_rdata", e, sb_rdata)
  endtask : rd
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // every offset, the unmapped one too, reads zero after reset
  task automatic t_reset;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    `XB_CHK("cs_host_lock", 4'h0, cs_lock)
    `XB_CHK("wakeup_ctrl_host_lock", 1'b0, wk_lock)
  endtask : t_reset
  // one lock at a time: its own select refused, the neighbour still forwarded
  task automatic t_lock;
    for (int c = 0; c < 4; c++) begin
      wr(3'h6, 8'h01 << c);
      `XB_CHK("cs_host_lock", 4'h1 << c, cs_lock)
      far_i.host_cycle(c[1:0]);
      `XB_CHK("lpc_deny", 1'b1, lpc_deny)
      `XB_CHK("lpc_go", 1'b0, lpc_go)
      far_i.host_cycle(c[1:0] + 2'h1);
      `XB_CHK("lpc_go", 1'b1, lpc_go)
      `XB_CHK("lpc_deny", 1'b0, lpc_deny)
    end
  endtask : t_lock
  // each response mode is reported and the flag is set again after clearing
  task automatic t_viol;
    wr(3'h6, 8'h08);
    for (int m = 0; m < 4; m++) begin
      wr(3'h1, {2'b00, m[1:0], 4'h0});
      wr(3'h0, 8'h04);
      rd(3'h0, 8'h00);
      far_i.host_cycle(2'h3);
      @(negedge clk);
      `XB_CHK("lpc_deny_mode", m[1:0], mode)
      rd(3'h0, 8'h04);
    end
    // a refusal landing on the clearing write must win
    wr(3'h0, 8'h04);
    rd(3'h0, 8'h00);
    fork
      wr(3'h0, 8'h04);
      far_i.host_cycle(2'h3);
    join
    rd(3'h0, 8'h04);
  endtask : t_viol
  // serial cycles pass with all four chip-select locks set
  task automatic t_serial;
    wr(3'h6, 8'h0f);
    for (int c = 0; c < 4; c++) begin
      far_i.serial_cycle(c[1:0]);
      `XB_CHK("acb_go", 1'b1, acb_go)
      `XB_CHK("go_cs", c[1:0], go_cs)
    end
  endtask : t_serial
  // reserved lock and config bits read zero, offset seven ignores writes
  task automatic t_mask;
    wr(3'h6, 8'hff);
    `XB_CHK("cs_host_lock", 4'hf, cs_lock)
    `XB_CHK("wakeup_ctrl_host_lock", 1'b1, wk_lock)
    rd(3'h6, `XBCSAL_MASK_LOCK_TWO);
    wr(3'h1, 8'hff);
    rd(3'h1, `XBCSAL_MASK_CONFIG);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
  endtask : t_mask
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_lock();
    t_viol();
    t_serial();
    t_mask();
    close_out();
  end
endmodule : tb_xbcsal_top

// ---- dv/xbcsal_far_model.sv ----
`timescale 1ns/1ps
// host and serial controller issuing cycles toward the expansion bus
module xbcsal_far_model (
  input  wire logic       clk,
  output logic            lpc_req,
  output logic      [1:0] lpc_cs,
  output logic            acb_req,
  output logic      [1:0] acb_cs
);
  // idle at time zero so no request is seen during reset
  initial begin
    lpc_req = 1'b0;
    lpc_cs  = 2'h0;
    acb_req = 1'b0;
    acb_cs  = 2'h0;
  end
  // one-cycle pulse; select is scrambled once released so stale values never match
  task automatic host_cycle(input logic [1:0] cs);
    @(negedge clk);
    lpc_req = 1'b1;
    lpc_cs  = cs;
    @(negedge clk);
    lpc_req = 1'b0;
    lpc_cs  = ~cs;
  endtask : host_cycle
  task automatic serial_cycle(input logic [1:0] cs);
    @(negedge clk);
    acb_req = 1'b1;
    acb_cs  = cs;
    @(negedge clk);
    acb_req = 1'b0;
    acb_cs  = ~cs;
  endtask : serial_cycle
endmodule : xbcsal_far_model

// ---- include/xbcsal_cfg.svh ----
`ifndef XBCSAL_CFG_SVH
`define XBCSAL_CFG_SVH
// register offsets on the serial management port
`define XBCSAL_OFS_CTRL_STATUS  3'h0
`define XBCSAL_OFS_CONFIG       3'h1
`define XBCSAL_OFS_LOCK_RELEASE 3'h2
`define XBCSAL_OFS_FUNC_DISABLE 3'h3
`define XBCSAL_OFS_PIN_TRISTATE 3'h4
`define XBCSAL_OFS_LOCK_ONE     3'h5
`define XBCSAL_OFS_LOCK_TWO     3'h6
// field positions
`define XBCSAL_BIT_VIOL_FLAG    2
`define XBCSAL_BIT_MODE_LO      4
`define XBCSAL_BIT_MODE_HI      5
`define XBCSAL_BIT_CS3_LOCK     3
`define XBCSAL_BIT_CS0_LOCK     0
// writable masks; reserved bits read zero
`define XBCSAL_MASK_CONFIG      8'hb1
`define XBCSAL_MASK_FUNC_DIS    8'h3f
`define XBCSAL_MASK_TRISTATE    8'h0f
`define XBCSAL_MASK_LOCK_ONE    8'h9f
`define XBCSAL_MASK_LOCK_TWO    8'hcf
// reset values
`define XBCSAL_RST_REG          8'h00
`endif

// ---- include/xbcsal_pkg.sv ----
package xbcsal_pkg;
  // whole state of the lock block, registered in one place
  typedef struct packed {
    logic [7:0] ctrl_status;
    logic [7:0] configuration;
    logic [7:0] lock_release;
    logic [7:0] func_disable;
    logic [7:0] pin_tristate;
    logic [7:0] lock_one;
    logic [7:0] lock_two;
    logic [7:0] rdata;
    logic       lpc_go;
    logic       lpc_deny;
    logic [1:0] deny_mode;
    logic       acb_go;
    logic [1:0] go_cs;
  } xbcsal_state_t;
endpackage : xbcsal_pkg

// ---- rtl/xbcsal_top.sv ----
`timescale 1ns/1ps
`include "xbcsal_cfg.svh"
// Contract
// RL1: cs3 lock set refuses host cycles to cs3
// RL2: cs3 lock reads zero after reset
// RL3: blocked region answered like locked wakeup module
// RL4: bit 2 locks chip select 2 likewise
// RL5: bit 1 locks chip select 1 likewise
// RL6: bit 0 locks chip select 0 likewise
// RL7: violation answers per mode, sets violation flag
// RL8: serial bus cycles never blocked by locks
module xbcsal_top (
  input  wire logic       clk,
  input  wire logic       rst,
  // serial management register port
  input  wire logic [2:0] sb_addr,
  input  wire logic       sb_wr,
  input  wire logic [7:0] sb_wdata,
  output logic      [7:0] sb_rdata,
  // host cycles aimed at the expansion bus
  input  wire logic       lpc_req,
  input  wire logic [1:0] lpc_cs,
  output logic            lpc_go,
  output logic            lpc_deny,
  output logic      [1:0] lpc_deny_mode,
  // serial bus cycles aimed at the expansion bus
  input  wire logic       acb_req,
  input  wire logic [1:0] acb_cs,
  output logic            acb_go,
  output logic      [1:0] go_cs,
  // lock bits for other modules of the device
  output logic            wakeup_ctrl_host_lock,
  output logic      [3:0] cs_host_lock
);
  import xbcsal_pkg::*;

  xbcsal_state_t s_r;
  xbcsal_state_t s_nxt;

  // one lock bit per chip select, looked up in the second lock register
  function automatic logic cs_locked(input logic [7:0] lock_reg, input logic [1:0] cs);
    cs_locked = lock_reg[`XBCSAL_BIT_CS0_LOCK + 32'(cs)];
  endfunction : cs_locked

  // register read mux; unused offsets read zero
  function automatic logic [7:0] reg_read(input xbcsal_state_t st, input logic [2:0] a);
    case (a)
      `XBCSAL_OFS_CTRL_STATUS:  reg_read = st.ctrl_status;
      `XBCSAL_OFS_CONFIG:       reg_read = st.configuration;
      `XBCSAL_OFS_LOCK_RELEASE: reg_read = st.lock_release;
      `XBCSAL_OFS_FUNC_DISABLE: reg_read = st.func_disable;
      `XBCSAL_OFS_PIN_TRISTATE: reg_read = st.pin_tristate;
      `XBCSAL_OFS_LOCK_ONE:     reg_read = st.lock_one;
      `XBCSAL_OFS_LOCK_TWO:     reg_read = st.lock_two;
      default:                  reg_read = 8'h00;
    endcase
  endfunction : reg_read

  logic host_hit_lock;
  assign host_hit_lock = lpc_req && cs_locked(s_r.lock_two, lpc_cs);

  // next state: register writes, host lockout, serial pass-through
  always_comb begin
    s_nxt = s_r;
    s_nxt.lpc_go   = 1'b0;
    s_nxt.lpc_deny = 1'b0;
    s_nxt.acb_go   = 1'b0;
    if (sb_wr) begin
      case (sb_addr)
        `XBCSAL_OFS_CTRL_STATUS: begin
          // write one clears the violation flag
          if (sb_wdata[`XBCSAL_BIT_VIOL_FLAG]) begin
            s_nxt.ctrl_status[`XBCSAL_BIT_VIOL_FLAG] = 1'b0;
          end
        end
        `XBCSAL_OFS_CONFIG:       s_nxt.configuration = sb_wdata & `XBCSAL_MASK_CONFIG;
        `XBCSAL_OFS_LOCK_RELEASE: s_nxt.lock_release  = sb_wdata;
        `XBCSAL_OFS_FUNC_DISABLE: s_nxt.func_disable  = sb_wdata & `XBCSAL_MASK_FUNC_DIS;
        `XBCSAL_OFS_PIN_TRISTATE: s_nxt.pin_tristate  = sb_wdata & `XBCSAL_MASK_TRISTATE;
        `XBCSAL_OFS_LOCK_ONE:     s_nxt.lock_one      = sb_wdata & `XBCSAL_MASK_LOCK_ONE;
        `XBCSAL_OFS_LOCK_TWO:     s_nxt.lock_two      = sb_wdata & `XBCSAL_MASK_LOCK_TWO;
        default: begin
        end
      endcase
    end
    // host cycle: locked regions are refused and answered per mode
    if (lpc_req) begin
      if (host_hit_lock) begin // RL1 RL4 RL5 RL6
        s_nxt.lpc_deny  = 1'b1; // RL3
        s_nxt.deny_mode = s_r.configuration[`XBCSAL_BIT_MODE_HI:`XBCSAL_BIT_MODE_LO]; // RL7
        // set placed after the clear so a same-cycle event wins
        s_nxt.ctrl_status[`XBCSAL_BIT_VIOL_FLAG] = 1'b1; // RL7
      end else begin
        s_nxt.lpc_go = 1'b1;
        s_nxt.go_cs  = lpc_cs;
      end
    end
    // serial bus owns the bus when both ask; locks never apply here
    if (acb_req) begin // RL8
      s_nxt.acb_go = 1'b1;
      s_nxt.lpc_go = 1'b0;
      s_nxt.go_cs  = acb_cs;
    end
    s_nxt.rdata = reg_read(s_nxt, sb_addr);
  end

  // state register; all locks open after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0; // RL2
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs come straight from the state flops
  assign sb_rdata              = s_r.rdata;
  assign lpc_go                = s_r.lpc_go;
  assign lpc_deny              = s_r.lpc_deny;
  assign lpc_deny_mode         = s_r.deny_mode;
  assign acb_go                = s_r.acb_go;
  assign go_cs                 = s_r.go_cs;
  assign wakeup_ctrl_host_lock = s_r.lock_two[7];
  assign cs_host_lock          = s_r.lock_two[3:0];

  // a host request to chip select n while its lock bit is set
  sequence s_host_locked(int n);
    lpc_req && !acb_req && (lpc_cs == 2'(n)) && s_r.lock_two[n];
  endsequence

  sequence s_refused;
    lpc_deny && !lpc_go;
  endsequence

  property p_cs3_refused;
    @(posedge clk) disable iff (rst)
      s_host_locked(3) |=> s_refused;
  endproperty
  a_cs3_refused: assert property (p_cs3_refused) else $error("cs3 lock not honoured"); // RL1

  property p_cs3_reset_open;
    @(posedge clk) disable iff (rst)
      $past(rst) |-> (s_r.lock_two[`XBCSAL_BIT_CS3_LOCK] == 1'b0) && (cs_host_lock == 4'h0);
  endproperty
  a_cs3_reset_open: assert property (p_cs3_reset_open) else $error("lock set after reset"); // RL2

  property p_same_answer;
    @(posedge clk) disable iff (rst)
      (lpc_req && !acb_req && cs_locked(s_r.lock_two, lpc_cs)) |=>
        lpc_deny && (lpc_deny_mode == $past(s_r.configuration[5:4]));
  endproperty
  a_same_answer: assert property (p_same_answer) else $error("deny mode mismatch"); // RL3

  property p_cs2_refused;
    @(posedge clk) disable iff (rst)
      s_host_locked(2) |=> s_refused;
  endproperty
  a_cs2_refused: assert property (p_cs2_refused) else $error("cs2 lock not honoured"); // RL4

  property p_cs1_refused;
    @(posedge clk) disable iff (rst)
      s_host_locked(1) |=> s_refused;
  endproperty
  a_cs1_refused: assert property (p_cs1_refused) else $error("cs1 lock not honoured"); // RL5

  property p_cs0_refused;
    @(posedge clk) disable iff (rst)
      s_host_locked(0) |=> s_refused;
  endproperty
  a_cs0_refused: assert property (p_cs0_refused) else $error("cs0 lock not honoured"); // RL6

  property p_flag_set;
    @(posedge clk) disable iff (rst)
      (lpc_req && !acb_req && cs_locked(s_r.lock_two, lpc_cs)) |=>
        s_r.ctrl_status[`XBCSAL_BIT_VIOL_FLAG] &&
        ($past(sb_addr) != `XBCSAL_OFS_CTRL_STATUS || sb_rdata[`XBCSAL_BIT_VIOL_FLAG]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("violation flag not set"); // RL7

  property p_open_passes;
    @(posedge clk) disable iff (rst)
      (lpc_req && !acb_req && !cs_locked(s_r.lock_two, lpc_cs)) |=>
        lpc_go && !lpc_deny && go_cs == $past(lpc_cs);
  endproperty
  a_open_passes: assert property (p_open_passes) else $error("open region refused"); // RL1

  property p_serial_free;
    @(posedge clk) disable iff (rst)
      acb_req |=> acb_go && go_cs == $past(acb_cs) && !lpc_go;
  endproperty
  a_serial_free: assert property (p_serial_free) else $error("serial cycle blocked"); // RL8

  // a refusal meeting a clearing write in one cycle must leave the flag set
  property p_set_beats_clear;
    @(posedge clk) disable iff (rst)
      (host_hit_lock && sb_wr && sb_addr == `XBCSAL_OFS_CTRL_STATUS) |=>
        s_r.ctrl_status[`XBCSAL_BIT_VIOL_FLAG];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("flag lost"); // RL7

  // writing one to the flag with no refusal pending clears it
  property p_flag_clears;
    @(posedge clk) disable iff (rst)
      (sb_wr && sb_addr == `XBCSAL_OFS_CTRL_STATUS && sb_wdata[`XBCSAL_BIT_VIOL_FLAG] &&
       !host_hit_lock) |=> !s_r.ctrl_status[`XBCSAL_BIT_VIOL_FLAG];
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared"); // RL7

  // a lock write reaches the chip-select lock outputs on the next cycle
  property p_lock_write;
    @(posedge clk) disable iff (rst)
      (sb_wr && sb_addr == `XBCSAL_OFS_LOCK_TWO) |=> cs_host_lock == $past(sb_wdata[3:0]);
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock write lost"); // RL1

  // a refusal is a single pulse unless another locked request follows
  property p_deny_pulse;
    @(posedge clk) disable iff (rst)
      (lpc_deny && !host_hit_lock) |=> !lpc_deny;
  endproperty
  a_deny_pulse: assert property (p_deny_pulse) else $error("refusal held too long"); // RL3

endmodule : xbcsal_top
